// [hw/timer16_map.svh]
// Register offsets, field positions, codes and reset values of the 16-bit timer.
// Assumes an 8-bit register port with a 3-bit word address.
`ifndef TIMER16_MAP_SVH
`define TIMER16_MAP_SVH

`define T16_ADDR_W 3
`define T16_DATA_W 8

`define T16_OFS_CONTROL 3'h0
`define T16_OFS_CMP_LOW 3'h1
`define T16_OFS_CMP_HIGH 3'h2
`define T16_OFS_COUNT_LOW 3'h3
`define T16_OFS_COUNT_HIGH 3'h4

`define T16_RUN_BIT 5
`define T16_CK_MSB 4
`define T16_CK_LSB 2
`define T16_MODE_BIT 0

`define T16_CK_TAP_A 3'h0
`define T16_CK_TAP_B 3'h1
`define T16_CK_TAP_C 3'h2
`define T16_CK_TAP_D 3'h3
`define T16_CK_HF_DIRECT 3'h4
`define T16_CK_LF_DIRECT 3'h5
`define T16_CK_RESERVED 3'h6
`define T16_CK_EXTERNAL 3'h7

`define T16_RUN_RST 1'b0
`define T16_CK_RST 3'h0
`define T16_MODE_RST 1'b0
`define T16_CMP_RST 16'hFFFF
`define T16_COUNT_RST 16'h0000
`define T16_COUNT_ONE 16'h0001
`define T16_RDATA_ZERO 8'h00

// Upper compare bits used when the high-frequency clock is counted directly
`define T16_FAST_CMP_LSB 11

// Prescaler chains and tap exponents
`define T16_HF_DIV_W 23
`define T16_LF_DIV_W 15
`define T16_HF_TAP_N 4
`define T16_LF_TAP_N 2
`define T16_HF_EXP_A 23
`define T16_HF_EXP_B 13
`define T16_HF_EXP_C 8
`define T16_HF_EXP_D 3
`define T16_LF_EXP_A 15
`define T16_LF_EXP_B 5

`endif

// [hw/timer16_pkg.sv]
// Types shared by the 16-bit timer files.
// Assumes timer16_map.svh supplies the widths.
`include "timer16_map.svh"

package timer16_pkg;
    typedef logic [15:0] count_t;
    typedef logic [2:0] clock_code_t;
    typedef logic [`T16_DATA_W-1:0] reg_byte_t;
    typedef logic [`T16_ADDR_W-1:0] reg_addr_t;
    typedef enum logic [2:0] {
        SRC_IDLE = 3'b001,
        SRC_INTERNAL = 3'b010,
        SRC_PIN_EDGE = 3'b100
    } count_source_t;
endpackage

// [hw/timer16_prescaler.sv]
// Prescaler chains for the 16-bit timer: divides the fc and fs tick enables.
// Assumes hf_tick_in and lf_tick_in are one-cycle enables on ref_clk_in.
`timescale 1ns/1ps
`default_nettype none
`include "timer16_map.svh"

module timer16_prescaler
    import timer16_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic hf_tick_in,
    input wire logic lf_tick_in,
    output logic [`T16_HF_TAP_N-1:0] hf_tap_out,
    output logic [`T16_LF_TAP_N-1:0] lf_tap_out
);
    localparam int HF_EXP [`T16_HF_TAP_N] = '{`T16_HF_EXP_A, `T16_HF_EXP_B, `T16_HF_EXP_C, `T16_HF_EXP_D};
    localparam int LF_EXP [`T16_LF_TAP_N] = '{`T16_LF_EXP_A, `T16_LF_EXP_B};

    logic [`T16_HF_DIV_W-1:0] hf_div_reg;
    logic [`T16_LF_DIV_W-1:0] lf_div_reg;

    // Free-running chains: taps stay phase-locked whatever the timer does
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            hf_div_reg <= '0;
            lf_div_reg <= '0;
        end else begin
            if (hf_tick_in) begin
                hf_div_reg <= hf_div_reg + 1'b1;
            end
            if (lf_tick_in) begin
                lf_div_reg <= lf_div_reg + 1'b1;
            end
        end
    end

    // A tap fires when its low chain bits are all ones at a tick
    genvar g;
    generate
        for (g = 0; g < `T16_HF_TAP_N; g++) begin : gen_hf_tap
            wire hf_wrap = hf_tick_in & (&hf_div_reg[HF_EXP[g]-1:0]);
            always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    hf_tap_out[g] <= 1'b0;
                end else begin
                    hf_tap_out[g] <= hf_wrap;
                end
            end
        end
        for (g = 0; g < `T16_LF_TAP_N; g++) begin : gen_lf_tap
            wire lf_wrap = lf_tick_in & (&lf_div_reg[LF_EXP[g]-1:0]);
            always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    lf_tap_out[g] <= 1'b0;
                end else begin
                    lf_tap_out[g] <= lf_wrap;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// [hw/timer16_pin_edges.sv]
// Counter pin sampler: registered level plus rising and falling edge pulses.
// Assumes the pin is synchronous to ref_clk_in.
`timescale 1ns/1ps
`default_nettype none

module timer16_pin_edges
    import timer16_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic counter_pin_in,
    output logic pin_level_out,
    output logic pin_rise_out,
    output logic pin_fall_out
);
    wire rise_now = counter_pin_in & ~pin_level_out;
    wire fall_now = ~counter_pin_in & pin_level_out;

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_level_out <= 1'b0;
            pin_rise_out <= 1'b0;
            pin_fall_out <= 1'b0;
        end else begin
            pin_level_out <= counter_pin_in;
            pin_rise_out <= rise_now;
            pin_fall_out <= fall_now;
        end
    end
endmodule
`default_nettype wire

// [hw/timer16_event_window_counter.sv]
// 16-bit timer with timer, event counter and window modes, behind an 8-bit register port.
// Assumes fc and fs arrive as one-cycle tick enables and power modes as levels on ref_clk_in.
`timescale 1ns/1ps
`default_nettype none
`include "timer16_map.svh"

module timer16_event_window_counter
    import timer16_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic [`T16_ADDR_W-1:0] reg_addr_in,
    input wire logic [`T16_DATA_W-1:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [`T16_DATA_W-1:0] reg_rdata_out,
    input wire logic hf_tick_in,
    input wire logic lf_tick_in,
    input wire logic prescaler_source_option_in,
    input wire logic slow_osc_stopped_mode_in,
    input wire logic slow_osc_running_mode_in,
    input wire logic stop_mode_entry_in,
    input wire logic counter_pin_in,
    output logic compare_match_irq_out
);
    ////////////////////////////////////////////////////////////////////////////
    // Storage
    logic run_control_reg;
    logic run_control_next;
    clock_code_t clock_select_reg;
    logic operating_mode_select_reg;
    count_t compare_reg;
    count_t compare_next;
    reg_byte_t compare_low_byte_reg;
    logic low_pending_reg;
    logic low_pending_next;
    count_t count_reg;
    count_t count_next;
    reg_byte_t rdata_next;

    logic [`T16_HF_TAP_N-1:0] hf_tap;
    logic [`T16_LF_TAP_N-1:0] lf_tap;
    logic pin_level;
    logic pin_rise;
    logic pin_fall;

    ////////////////////////////////////////////////////////////////////////////
    // Clock sources
    timer16_prescaler u_prescaler (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .hf_tick_in(hf_tick_in),
        .lf_tick_in(lf_tick_in),
        .hf_tap_out(hf_tap),
        .lf_tap_out(lf_tap)
    );

    // Pin edges lag the pin by one cycle, in step for the event counter and window modes
    timer16_pin_edges u_pin_edges (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .counter_pin_in(counter_pin_in),
        .pin_level_out(pin_level),
        .pin_rise_out(pin_rise),
        .pin_fall_out(pin_fall)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register decode
    wire wr_control = reg_write_in & (reg_addr_in == `T16_OFS_CONTROL);
    wire wr_cmp_low = reg_write_in & (reg_addr_in == `T16_OFS_CMP_LOW);
    wire wr_cmp_high = reg_write_in & (reg_addr_in == `T16_OFS_CMP_HIGH);
    wire rd_control = reg_addr_in == `T16_OFS_CONTROL;
    wire rd_count_low = reg_addr_in == `T16_OFS_COUNT_LOW;
    wire rd_count_high = reg_addr_in == `T16_OFS_COUNT_HIGH;

    ////////////////////////////////////////////////////////////////////////////
    // Count source selection
    wire slow_mode = slow_osc_stopped_mode_in | slow_osc_running_mode_in;
    wire use_lf_taps = slow_mode | prescaler_source_option_in;
    wire window_mode = operating_mode_select_reg;
    wire code_a = clock_select_reg == `T16_CK_TAP_A;
    wire code_b = clock_select_reg == `T16_CK_TAP_B;
    wire code_c = clock_select_reg == `T16_CK_TAP_C;
    wire code_d = clock_select_reg == `T16_CK_TAP_D;
    wire code_hf = clock_select_reg == `T16_CK_HF_DIRECT;
    wire code_lf = clock_select_reg == `T16_CK_LF_DIRECT;
    wire code_ext = clock_select_reg == `T16_CK_EXTERNAL;

    wire src_a = use_lf_taps ? lf_tap[0] : hf_tap[0];
    wire src_b = use_lf_taps ? lf_tap[1] : hf_tap[1];
    wire src_c = ~slow_mode & hf_tap[2];
    wire src_d = ~slow_mode & hf_tap[3];
    // fc straight in only for timer mode while fc keeps running in slow mode
    wire hf_direct_ok = slow_osc_running_mode_in & ~window_mode;
    wire src_hf = hf_direct_ok & hf_tick_in;
    wire src_lf = ~slow_mode & lf_tick_in;
    // Reserved code 110 selects nothing, so the counter just stands
    wire internal_tick = (code_a & src_a) | (code_b & src_b) | (code_c & src_c)
                       | (code_d & src_d) | (code_hf & src_hf) | (code_lf & src_lf);

    wire fast_compare = code_hf & hf_direct_ok;
    count_source_t source_kind;
    assign source_kind = !run_control_reg ? SRC_IDLE
                       : (code_ext && !window_mode) ? SRC_PIN_EDGE
                       : SRC_INTERNAL;

    ////////////////////////////////////////////////////////////////////////////
    // Count and match
    wire count_step_internal = window_mode ? (internal_tick & pin_level)
                                           : internal_tick;
    wire [15:0] count_plus = count_reg + `T16_COUNT_ONE;
    wire full_hit = count_plus == compare_reg;
    wire upper_hit = count_plus[15:`T16_FAST_CMP_LSB] == compare_reg[15:`T16_FAST_CMP_LSB];
    wire step_hit = fast_compare ? upper_hit : full_hit;
    wire event_hit = pin_fall & (count_reg == compare_reg);

    logic count_step;
    logic match_now;
    always_comb begin
        count_step = 1'b0;
        match_now = 1'b0;
        case (source_kind)
            SRC_IDLE: begin
                count_step = 1'b0;
                match_now = 1'b0;
            end
            SRC_INTERNAL: begin
                count_step = count_step_internal;
                match_now = count_step_internal & step_hit;
            end
            SRC_PIN_EDGE: begin
                count_step = pin_rise;
                match_now = event_hit;
            end
            default: begin
                count_step = 1'b0;
                match_now = 1'b0;
            end
        endcase
    end

    assign count_next = !run_control_reg ? `T16_COUNT_RST
                      : match_now ? `T16_COUNT_RST
                      : count_step ? count_plus
                      : count_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Control and compare writes
    // Stop-mode entry beats a same-cycle start so the timer never runs on a dead clock
    assign run_control_next = stop_mode_entry_in ? 1'b0
                            : wr_control ? reg_wdata_in[`T16_RUN_BIT]
                            : run_control_reg;

    // Only the high byte commits; a low byte alone just waits
    wire commit_compare = wr_cmp_high & (low_pending_reg | fast_compare);
    assign compare_next = commit_compare ? {reg_wdata_in, compare_low_byte_reg} : compare_reg;
    assign low_pending_next = wr_cmp_low ? 1'b1 : (wr_cmp_high ? 1'b0 : low_pending_reg);

    ////////////////////////////////////////////////////////////////////////////
    // Read path: data stands only in the cycle after the read strobe
    wire [7:0] control_view = {2'b00, run_control_reg, clock_select_reg, 1'b0, operating_mode_select_reg};
    assign rdata_next = !reg_read_in ? `T16_RDATA_ZERO
                      : rd_control ? control_view
                      : rd_count_low ? count_reg[7:0]
                      : rd_count_high ? count_reg[15:8]
                      : `T16_RDATA_ZERO;

    ////////////////////////////////////////////////////////////////////////////
    // Flip-flops
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            run_control_reg <= `T16_RUN_RST;
            clock_select_reg <= `T16_CK_RST;
            operating_mode_select_reg <= `T16_MODE_RST;
        end else begin
            run_control_reg <= run_control_next;
            if (wr_control) begin
                clock_select_reg <= reg_wdata_in[`T16_CK_MSB:`T16_CK_LSB];
                operating_mode_select_reg <= reg_wdata_in[`T16_MODE_BIT];
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            compare_reg <= `T16_CMP_RST;
            compare_low_byte_reg <= `T16_RDATA_ZERO;
            low_pending_reg <= 1'b0;
        end else begin
            compare_reg <= compare_next;
            low_pending_reg <= low_pending_next;
            if (wr_cmp_low) begin
                compare_low_byte_reg <= reg_wdata_in;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            count_reg <= `T16_COUNT_RST;
            compare_match_irq_out <= 1'b0;
            reg_rdata_out <= `T16_RDATA_ZERO;
        end else begin
            count_reg <= count_next;
            compare_match_irq_out <= match_now;
            reg_rdata_out <= rdata_next;
        end
    end
endmodule
`default_nettype wire

// [sim/timer16_checker.sv]
// Port-level assertions for the 16-bit timer, bound into the design top.
// Assumes timer16_map.svh and timer16_pkg are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "timer16_map.svh"

module timer16_checker
    import timer16_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic [`T16_ADDR_W-1:0] reg_addr_in,
    input wire logic [`T16_DATA_W-1:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [`T16_DATA_W-1:0] reg_rdata_out,
    input wire logic hf_tick_in,
    input wire logic lf_tick_in,
    input wire logic prescaler_source_option_in,
    input wire logic slow_osc_stopped_mode_in,
    input wire logic slow_osc_running_mode_in,
    input wire logic stop_mode_entry_in,
    input wire logic counter_pin_in,
    input wire logic compare_match_irq_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);

    ////////////////////////////////////////////////////////////////////////////////
    // Shadow of the control fields, rebuilt from bus writes
    logic run_reg;
    logic mode_reg;
    clock_code_t ck_reg;
    wire logic ctl_wr = reg_write_in && (reg_addr_in == `T16_OFS_CONTROL);

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            run_reg <= `T16_RUN_RST;
            ck_reg <= `T16_CK_RST;
            mode_reg <= `T16_MODE_RST;
        end else if (stop_mode_entry_in) begin
            run_reg <= 1'b0;
        end else if (ctl_wr) begin
            run_reg <= reg_wdata_in[`T16_RUN_BIT];
            ck_reg <= reg_wdata_in[`T16_CK_MSB:`T16_CK_LSB];
            mode_reg <= reg_wdata_in[`T16_MODE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    property p_irq_pulse;
        compare_match_irq_out |=> !compare_match_irq_out;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq held over one cycle");
    property p_rdata_idle;
        !reg_read_in |=> reg_rdata_out == `T16_RDATA_ZERO;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
    property p_ctl_readback;
        reg_read_in && reg_addr_in == `T16_OFS_CONTROL
            |=> reg_rdata_out == {2'b00, $past(run_reg), $past(ck_reg), 1'b0, $past(mode_reg)};
    endproperty
    a_ctl_readback: assert property (p_ctl_readback) else $error("control readback wrong");
    property p_cmp_unreadable;
        reg_read_in && (reg_addr_in == `T16_OFS_CMP_LOW || reg_addr_in == `T16_OFS_CMP_HIGH
            || reg_addr_in > `T16_OFS_COUNT_HIGH) |=> reg_rdata_out == `T16_RDATA_ZERO;
    endproperty
    a_cmp_unreadable: assert property (p_cmp_unreadable) else $error("write-only read nonzero");
    // Six quiet cycles leave room for a match launched at the stopping edge
    property p_stop_clear;
        stop_mode_entry_in ##1 (!reg_write_in)[*6] |-> !compare_match_irq_out;
    endproperty
    a_stop_clear: assert property (p_stop_clear) else $error("irq after stop entry");
    property p_run_stop;
        ctl_wr && !reg_wdata_in[`T16_RUN_BIT] ##1 (!reg_write_in)[*6] |-> !compare_match_irq_out;
    endproperty
    a_run_stop: assert property (p_run_stop) else $error("irq while stopped");
    property p_reserved;
        compare_match_irq_out |-> !(ck_reg == `T16_CK_RESERVED && $past(ck_reg) == `T16_CK_RESERVED
            && $past(ck_reg, 2) == `T16_CK_RESERVED);
    endproperty
    a_reserved: assert property (p_reserved) else $error("irq on reserved clock code");
    property p_event_fall;
        compare_match_irq_out && !$past(mode_reg, 2) && $past(ck_reg, 2) == `T16_CK_EXTERNAL
            |-> !$past(counter_pin_in, 2);
    endproperty
    a_event_fall: assert property (p_event_fall) else $error("event irq not after fall");

    c_event_irq: cover property (compare_match_irq_out && ck_reg == `T16_CK_EXTERNAL);
    c_window_irq: cover property (compare_match_irq_out && mode_reg);
    c_stop_entry: cover property (stop_mode_entry_in && run_reg);
endmodule

bind timer16_event_window_counter timer16_checker timer16_checker_i (.ref_clk_in, .rst_b_in, .reg_addr_in,
    .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out, .hf_tick_in, .lf_tick_in,
    .prescaler_source_option_in, .slow_osc_stopped_mode_in, .slow_osc_running_mode_in,
    .stop_mode_entry_in, .counter_pin_in, .compare_match_irq_out);
`default_nettype wire

// [sim/timer16_pin_source.sv]
// Pulse or gate source that drives the timer's counter pin.
// Assumes one request per go pulse; the pin rests low between bursts.
`timescale 1ns/1ps
`default_nettype none

module timer16_pin_source (
    input wire logic ref_clk_in,
    input wire logic go_in,
    input wire logic [7:0] pulses_in,
    input wire logic [7:0] phase_in,
    output logic busy_out,
    output logic counter_pin_out
);
    int n;
    int ph;
    // One process owns both outputs, so each has a single driver
    initial begin
        busy_out = 1'b0;
        counter_pin_out = 1'b0;
        forever begin
            @(posedge ref_clk_in);
            if (go_in) begin
                busy_out <= 1'b1;
                n = pulses_in;
                ph = (phase_in < 8'h02) ? 2 : phase_in;
                // Long phases double as a slow window gate
                repeat (n) begin
                    counter_pin_out <= 1'b1;
                    repeat (ph) @(posedge ref_clk_in);
                    counter_pin_out <= 1'b0;
                    repeat (ph) @(posedge ref_clk_in);
                end
                busy_out <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// [sim/timer16_event_window_counter_tb.sv]
// Self-checking bench for the 16-bit timer: register tasks and counting scenarios.
// Assumes the checker is bound by its own file and the pin source drives the pin.
`timescale 1ns/1ps
`default_nettype none
`include "timer16_map.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end

module timer16_event_window_counter_tb
    import timer16_pkg::*;
;
    logic ref_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    reg_addr_t reg_addr_in = '0;
    reg_byte_t reg_wdata_in = '0;
    logic reg_write_in = 1'b0, reg_read_in = 1'b0, stop_mode_entry_in = 1'b0;
    logic prescaler_source_option_in = 1'b0, slow_osc_stopped_mode_in = 1'b0, slow_osc_running_mode_in = 1'b0;
    logic hf_tick_in = 1'b1, lf_tick_in = 1'b1, go = 1'b0, busy, counter_pin_in, compare_match_irq_out;
    logic [7:0] pulses = 8'h00, phase = 8'h00;
    reg_byte_t reg_rdata_out;
    int num_errors = 0, checks = 0, irq_seen = 0;
    clock_code_t codes [8] = '{3'h3, 3'h2, 3'h1, 3'h5, 3'h1, 3'h3, 3'h6, 3'h4};
    logic [2:0] pms [8] = '{3'h0, 3'h0, 3'h4, 3'h0, 3'h2, 3'h2, 3'h0, 3'h0};
    int exps [8] = '{24, 768, 192, 6, 192, 0, 0, 0};

    always #4 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) if (compare_match_irq_out === 1'b1) irq_seen <= irq_seen + 1;
    // Half-rate fs ticks keep fs sources apart from fc sources
    always @(posedge ref_clk_in) lf_tick_in <= ~lf_tick_in;

    timer16_event_window_counter timer16_event_window_counter_i (.ref_clk_in, .rst_b_in, .reg_addr_in,
        .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out, .hf_tick_in, .lf_tick_in,
        .prescaler_source_option_in, .slow_osc_stopped_mode_in, .slow_osc_running_mode_in,
        .stop_mode_entry_in, .counter_pin_in, .compare_match_irq_out);
    timer16_pin_source timer16_pin_source_i (.ref_clk_in, .go_in(go), .pulses_in(pulses),
        .phase_in(phase), .busy_out(busy), .counter_pin_out(counter_pin_in));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic wr(input reg_addr_t a, input reg_byte_t d);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_write_in <= 1'b0;
        #1;
    endtask
    task automatic rd(input reg_addr_t a, output reg_byte_t d);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_read_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask
    task automatic cmp(input logic [15:0] v);
        wr(`T16_OFS_CMP_LOW, v[7:0]);
        wr(`T16_OFS_CMP_HIGH, v[15:8]);
    endtask
    // Stops first: clock and mode may only change while stopped
    task automatic start(input clock_code_t ck, input logic mode, input logic [2:0] pm);
        wr(`T16_OFS_CONTROL, 8'h00);
        @(posedge ref_clk_in);
        {prescaler_source_option_in, slow_osc_stopped_mode_in, slow_osc_running_mode_in} <= pm;
        wr(`T16_OFS_CONTROL, {3'b000, ck, 1'b0, mode});
        wr(`T16_OFS_CONTROL, {3'b001, ck, 1'b0, mode});
    endtask
    task automatic wait_irq(input int lim, output int n);
        n = 0;
        while (compare_match_irq_out !== 1'b1 && n < lim) begin
            @(posedge ref_clk_in);
            #1 n++;
        end
    endtask
    // Zero expected period means no match may occur within lim cycles
    task automatic period(input int exp, input int lim);
        int n;
        wait_irq(lim, n);
        if (exp == 0) begin
            `CHK(n, lim)
        end else begin
            if (n >= lim) begin
                num_errors++;
                $display("wrong value at %0t: no compare match", $time);
                results();
            end
            @(posedge ref_clk_in);
            #1 wait_irq(lim, n);
            `CHK(n + 1, exp)
        end
    endtask
    task automatic pulse(input logic [7:0] n, input logic [7:0] ph);
        int k;
        @(posedge ref_clk_in);
        pulses <= n;
        phase <= ph;
        go <= 1'b1;
        @(posedge ref_clk_in);
        go <= 1'b0;
        #1 k = 0;
        while (busy === 1'b1 && k < 3000) begin
            @(posedge ref_clk_in);
            #1 k++;
        end
        if (k >= 3000) begin
            num_errors++;
            $display("wrong value at %0t: pin source hung", $time);
            results();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        reg_byte_t d;
        reg_byte_t c1;
        int base;
        repeat (3) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        rd(`T16_OFS_CONTROL, d); `CHK(d, 8'h00)
        rd(`T16_OFS_COUNT_LOW, d); `CHK(d, 8'h00)
        rd(3'h7, d); `CHK(d, 8'h00)
        wr(`T16_OFS_CONTROL, 8'h0D);
        rd(`T16_OFS_CONTROL, d); `CHK(d, 8'h0D)
        wr(`T16_OFS_CONTROL, 8'hFF);
        rd(`T16_OFS_CONTROL, d); `CHK(d, 8'h3D)
        $display("test registers done");
        cmp(16'h0003);
        for (int i = 0; i < 8; i++) begin
            start(codes[i], 1'b0, pms[i]);
            period(exps[i], 2 * exps[i] + 300);
        end
        $display("test clock codes done");
        start(3'h3, 1'b0, 3'h0);
        period(24, 400);
        wr(`T16_OFS_CMP_LOW, 8'h05);
        period(24, 400);
        wr(`T16_OFS_CMP_HIGH, 8'h00);
        period(40, 400);
        wr(`T16_OFS_CMP_HIGH, 8'h01);
        period(40, 400);
        wr(`T16_OFS_CONTROL, 8'h0C);
        period(0, 300);
        rd(`T16_OFS_COUNT_LOW, d); `CHK(d, 8'h00)
        $display("test compare pairing done");
        // Upper compare bits stay above 1 before the fast clock runs
        cmp(16'h1800);
        start(3'h4, 1'b0, 3'h1);
        wr(`T16_OFS_CMP_HIGH, 8'h10);
        period(4096, 9000);
        $display("test fast clock done");
        start(3'h3, 1'b0, 3'h0);
        cmp(16'h0003);
        @(posedge ref_clk_in);
        stop_mode_entry_in <= 1'b1;
        @(posedge ref_clk_in);
        stop_mode_entry_in <= 1'b0;
        rd(`T16_OFS_CONTROL, d); `CHK(d, 8'h0C)
        period(0, 300);
        $display("test stop entry done");
        start(3'h7, 1'b0, 3'h0);
        base = irq_seen;
        pulse(8'h03, 8'h06);
        `CHK(irq_seen - base, 1)
        rd(`T16_OFS_COUNT_LOW, d); `CHK(d, 8'h00)
        pulse(8'h02, 8'h06);
        rd(`T16_OFS_COUNT_LOW, d); `CHK(d, 8'h02)
        $display("test event counter done");
        start(3'h3, 1'b1, 3'h0);
        rd(`T16_OFS_COUNT_LOW, d); `CHK(d, 8'h00)
        base = irq_seen;
        pulse(8'h01, 8'h28);
        `CHK(irq_seen - base, 1)
        rd(`T16_OFS_COUNT_LOW, c1);
        `CHK(c1, 8'h02)
        repeat (20) @(posedge ref_clk_in);
        rd(`T16_OFS_COUNT_LOW, d); `CHK(d, c1)
        pulse(8'h01, 8'h10);
        `CHK(irq_seen - base, 2)
        rd(`T16_OFS_COUNT_LOW, d); `CHK(d, 8'h01)
        $display("test window done");
        results();
    end
    initial begin
        repeat (100000) @(posedge ref_clk_in);
        num_errors++;
        $display("wrong value at %0t: run too long", $time);
        results();
    end
endmodule
`default_nettype wire
